// ---- psag_cfg.svh ----
`ifndef PSAG_CFG_SVH
`define PSAG_CFG_SVH

// Bus widths of the RAM die, and the width of the controller counters
`define PSAG_ADDR_W          21
`define PSAG_DATA_W          16
`define PSAG_CNT_W           12

// Clock and timing figures in ns
`define PSAG_CLK_PERIOD_NS   10
`define PSAG_READ_CYCLE_NS   70
`define PSAG_WRITE_CYCLE_NS  70
`define PSAG_MIN_PULSE_NS    10
`define PSAG_WINDOW_NS       4000
`define PSAG_MAX_LEVEL_NS    10000

// Least times round up, longest times round down
`define PSAG_RC_CYC \
    ((`PSAG_READ_CYCLE_NS + `PSAG_CLK_PERIOD_NS - 1) / `PSAG_CLK_PERIOD_NS)
`define PSAG_WC_CYC \
    ((`PSAG_WRITE_CYCLE_NS + `PSAG_CLK_PERIOD_NS - 1) / `PSAG_CLK_PERIOD_NS)
`define PSAG_MIN_CYC \
    ((`PSAG_MIN_PULSE_NS + `PSAG_CLK_PERIOD_NS - 1) / `PSAG_CLK_PERIOD_NS)
`define PSAG_WIN_CYC  (`PSAG_WINDOW_NS / `PSAG_CLK_PERIOD_NS)
`define PSAG_LVL_CYC  (`PSAG_MAX_LEVEL_NS / `PSAG_CLK_PERIOD_NS)

// Input synchroniser latency added to every read phase
`define PSAG_SYNC_LAT 4
`define PSAG_RD_CYC   (`PSAG_RC_CYC + `PSAG_SYNC_LAT)
`define PSAG_GAP_CYC \
    ((`PSAG_RC_CYC > `PSAG_WC_CYC) ? `PSAG_RC_CYC : `PSAG_WC_CYC)
`define PSAG_SEL_LIMIT \
    (`PSAG_WIN_CYC - 2 * (`PSAG_RD_CYC + `PSAG_WC_CYC + `PSAG_MIN_CYC + 2))

// Reset values
`define PSAG_PIN_IDLE 1'b1
`define PSAG_CNT_RST  12'h000

`endif

// ---- psag_pkg.sv ----
package psag_pkg;
`include "psag_cfg.svh"

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_READ,
        ST_WRITE,
        ST_WREC,
        ST_GAP
    } psag_state_t;

    typedef struct packed {
        logic                    write;
        logic [`PSAG_ADDR_W-1:0] addr;
        logic [`PSAG_DATA_W-1:0] wdata;
        logic                    upper_n;
        logic                    lower_n;
    } psag_req_t;

    typedef struct packed {
        logic                    cs_n;
        logic                    oe_n;
        logic                    we_n;
        logic                    ram_upper_byte_enable_n;
        logic                    ram_lower_byte_enable_n;
        logic [`PSAG_ADDR_W-1:0] addr;
        logic [`PSAG_DATA_W-1:0] dq_out;
        logic                    dq_oe_n;
    } psag_pins_t;

endpackage

// ---- psag_sync3.sv ----
`timescale 1ns/1ps
module psag_sync3 #(
    parameter int W = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] held;
    logic [W-1:0] next_held;

    // Bus bits settle at different times; accept only agreeing stages
    always_comb begin
        next_held = held;
        if (ff2 == ff3) begin
            next_held = ff3;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ff1  <= '0;
            ff2  <= '0;
            ff3  <= '0;
            held <= '0;
        end else begin
            ff1  <= i_async;
            ff2  <= ff1;
            ff3  <= ff2;
            held <= next_held;
        end
    end

    assign o_sync = held;
endmodule

// ---- psag_top.sv ----
`timescale 1ns/1ps
`include "psag_cfg.svh"
module psag_top (
    input  wire logic                    I_SYS_CLK,
    input  wire logic                    I_RST,
    input  wire logic                    I_REQ_VALID,
    input  wire psag_pkg::psag_req_t     I_REQ,
    output logic                         O_REQ_READY,
    output logic [`PSAG_DATA_W-1:0]      O_RDATA,
    output logic                         O_RVALID,
    output psag_pkg::psag_pins_t         O_RAM,
    input  wire logic [`PSAG_DATA_W-1:0] I_RAM_DQ
);
    import psag_pkg::*;

    psag_state_t             state;
    psag_state_t             next_state;
    logic [`PSAG_CNT_W-1:0]  cnt;
    logic [`PSAG_CNT_W-1:0]  next_cnt;
    logic [`PSAG_CNT_W-1:0]  sel_cnt;
    logic [`PSAG_CNT_W-1:0]  next_sel_cnt;
    logic                    held;
    logic                    next_held;
    psag_req_t               req;
    psag_req_t               next_req;
    psag_pins_t              pins;
    psag_pins_t              next_pins;
    logic [`PSAG_DATA_W-1:0] rdata;
    logic [`PSAG_DATA_W-1:0] next_rdata;
    logic                    rvalid;
    logic                    next_rvalid;
    logic [`PSAG_DATA_W-1:0] dq_sync;
    logic                    can_go;
    logic                    ready;
    logic                    take;

    psag_sync3 #(
        .W(`PSAG_DATA_W)
    ) u_dq_sync (
        .i_clk  (I_SYS_CLK),
        .i_rst  (I_RST),
        .i_async(I_RAM_DQ),
        .o_sync (dq_sync)
    );

    // Margin covers two more whole accesses before the window closes
    assign can_go = sel_cnt < `PSAG_CNT_W'(`PSAG_SEL_LIMIT);

    always_comb begin
        ready = 1'b0;
        unique case (state)
            ST_IDLE: ready = 1'b1;
            ST_READ: begin
                ready = (cnt == `PSAG_CNT_W'(`PSAG_RD_CYC - 1)) && can_go
                        && !I_REQ.write;
            end
            ST_WREC: begin
                ready = (cnt == `PSAG_CNT_W'(`PSAG_MIN_CYC - 1)) && can_go
                        && I_REQ.write;
            end
            default: ready = 1'b0;
        endcase
        take = ready && I_REQ_VALID;
    end

    always_comb begin
        next_state   = state;
        next_cnt     = cnt + 12'h001;
        next_sel_cnt = sel_cnt;
        next_held    = held;
        next_req     = req;
        next_rdata   = rdata;
        next_rvalid  = 1'b0;
        if (!pins.cs_n) begin
            next_sel_cnt = sel_cnt + 12'h001;
        end
        unique case (state)
            ST_IDLE: begin
                next_cnt  = `PSAG_CNT_RST;
                next_held = 1'b0;
                if (take) begin
                    next_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                next_cnt   = `PSAG_CNT_RST;
                next_state = req.write ? ST_WRITE : ST_READ;
            end
            ST_READ: begin
                // Phase spans a full read cycle plus synchroniser delay
                if (cnt == `PSAG_CNT_W'(`PSAG_RD_CYC - 1)) begin
                    next_cnt    = `PSAG_CNT_RST;
                    next_rdata  = dq_sync;
                    next_rvalid = 1'b1;
                    if (!take) begin
                        next_state = ST_GAP;
                    end
                end
            end
            ST_WRITE: begin
                if (cnt == `PSAG_CNT_W'(`PSAG_WC_CYC - 1)) begin
                    next_cnt   = `PSAG_CNT_RST;
                    next_state = ST_WREC;
                end
            end
            ST_WREC: begin
                if (cnt == `PSAG_CNT_W'(`PSAG_MIN_CYC - 1)) begin
                    next_cnt = `PSAG_CNT_RST;
                    if (take) begin
                        next_held  = 1'b1;
                        next_state = ST_SETUP;
                    end else begin
                        next_state = ST_GAP;
                    end
                end
            end
            ST_GAP: begin
                next_sel_cnt = `PSAG_CNT_RST;
                // Gap of a full cycle time also serves as refresh slot
                if (cnt == `PSAG_CNT_W'(`PSAG_GAP_CYC - 1)) begin
                    next_cnt   = `PSAG_CNT_RST;
                    next_state = ST_IDLE;
                end
            end
        endcase
        if (take) begin
            next_req = I_REQ;
        end
    end

    always_comb begin
        next_pins                         = pins;
        next_pins.cs_n                    = `PSAG_PIN_IDLE;
        next_pins.oe_n                    = `PSAG_PIN_IDLE;
        next_pins.we_n                    = `PSAG_PIN_IDLE;
        next_pins.ram_upper_byte_enable_n = `PSAG_PIN_IDLE;
        next_pins.ram_lower_byte_enable_n = `PSAG_PIN_IDLE;
        next_pins.dq_oe_n                 = `PSAG_PIN_IDLE;
        unique case (next_state)
            ST_SETUP: begin
                // Address settles before select falls or before we strobes
                next_pins.addr = next_req.addr;
                next_pins.cs_n = !next_held;
                next_pins.ram_upper_byte_enable_n =
                    next_held ? pins.ram_upper_byte_enable_n : 1'b1;
                next_pins.ram_lower_byte_enable_n =
                    next_held ? pins.ram_lower_byte_enable_n : 1'b1;
                next_pins.dq_oe_n = !next_held;
            end
            ST_READ: begin
                next_pins.addr                    = next_req.addr;
                next_pins.cs_n                    = 1'b0;
                next_pins.oe_n                    = 1'b0;
                next_pins.ram_upper_byte_enable_n = 1'b0;
                next_pins.ram_lower_byte_enable_n = 1'b0;
            end
            ST_WRITE: begin
                next_pins.cs_n                    = 1'b0;
                next_pins.we_n                    = 1'b0;
                next_pins.ram_upper_byte_enable_n = req.upper_n;
                next_pins.ram_lower_byte_enable_n = req.lower_n;
                next_pins.dq_out                  = req.wdata;
                next_pins.dq_oe_n                 = 1'b0;
            end
            ST_WREC: begin
                next_pins.cs_n                    = 1'b0;
                next_pins.ram_upper_byte_enable_n =
                    pins.ram_upper_byte_enable_n;
                next_pins.ram_lower_byte_enable_n =
                    pins.ram_lower_byte_enable_n;
                next_pins.dq_oe_n                 = 1'b0;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            state   <= ST_IDLE;
            cnt     <= `PSAG_CNT_RST;
            sel_cnt <= `PSAG_CNT_RST;
            held    <= 1'b0;
            req     <= '0;
            rdata   <= '0;
            rvalid  <= 1'b0;
            pins    <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                         ram_upper_byte_enable_n: 1'b1,
                         ram_lower_byte_enable_n: 1'b1,
                         addr: '0, dq_out: '0, dq_oe_n: 1'b1};
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            sel_cnt <= next_sel_cnt;
            held    <= next_held;
            req     <= next_req;
            rdata   <= next_rdata;
            rvalid  <= next_rvalid;
            pins    <= next_pins;
        end
    end

    assign O_REQ_READY = ready;
    assign O_RDATA     = rdata;
    assign O_RVALID    = rvalid;
    assign O_RAM       = pins;

    // Helper counters for the long level checks
    logic [`PSAG_CNT_W-1:0] oe_hi_cnt;
    logic [`PSAG_CNT_W-1:0] we_lo_run;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST || pins.cs_n || !pins.oe_n) begin
            oe_hi_cnt <= `PSAG_CNT_RST;
        end else begin
            oe_hi_cnt <= oe_hi_cnt + 12'h001;
        end
        if (I_RST || pins.cs_n) begin
            we_lo_run <= `PSAG_CNT_RST;
        end else begin
            we_lo_run <= we_lo_run + 12'h001;
        end
    end

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);

    chk_oe_we_excl: assert property (!(!pins.oe_n && !pins.we_n))
        else $error("output and write enable low together");
    chk_cs_gap_width: assert property (
        $rose(pins.cs_n) |-> pins.cs_n[*2])
        else $error("chip select high pulse too short");
    chk_ub_high_width: assert property (
        $rose(pins.ram_upper_byte_enable_n)
        |-> pins.ram_upper_byte_enable_n[*2])
        else $error("upper byte enable high pulse too short");
    chk_lb_high_width: assert property (
        $rose(pins.ram_lower_byte_enable_n)
        |-> pins.ram_lower_byte_enable_n[*2])
        else $error("lower byte enable high pulse too short");
    chk_oe_high_max: assert property (
        oe_hi_cnt < `PSAG_CNT_W'(`PSAG_LVL_CYC))
        else $error("output enable high too long under select");
    chk_cs_to_oe: assert property (
        $fell(pins.cs_n) |-> ##[0:1000] (!pins.oe_n || pins.cs_n))
        else $error("output enable late after select");
    chk_addr_stable_cs: assert property ($fell(pins.cs_n) |->
        $stable(pins.addr))
        else $error("address moved as select fell");
    chk_addr_we_hold: assert property (
        (!pins.we_n || $fell(pins.we_n)) |-> $stable(pins.addr))
        else $error("address moved during write strobe");
    chk_sel_window: assert property (
        we_lo_run < `PSAG_CNT_W'(`PSAG_WIN_CYC))
        else $error("selected longer than refresh window");
    chk_we_after_oe: assert property (
        ($fell(pins.we_n) && !pins.cs_n) |-> $past(pins.oe_n))
        else $error("write enable fell with output enable low");
    chk_oe_after_we: assert property (
        ($rose(pins.we_n) && !pins.cs_n) |-> pins.oe_n[*2])
        else $error("output enable too soon after write");
    chk_write_release: assert property (
        (state == ST_WREC && !can_go && cnt == 12'h000) |->
        ##1 (state == ST_GAP) ##1 pins.cs_n[*7])
        else $error("write burst not released in window");
endmodule

// ---- psag_ram_model.sv ----
`timescale 1ns/1ps
`include "psag_cfg.svh"
module psag_ram_model (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire psag_pkg::psag_pins_t i_pins,
    output logic [`PSAG_DATA_W-1:0]   o_dq,
    output logic [8:0]                o_viol
);
    import psag_pkg::*;
    logic [`PSAG_DATA_W-1:0] mem [logic [`PSAG_ADDR_W-1:0]];
    logic [`PSAG_DATA_W-1:0] last;
    psag_pins_t              prev;
    int                      cs_hi, cs_lo, oe_hi, we_ok, since_w;
    int                      rd_ok, since_r;
    int                      ub_hi, lb_hi, we_hi;
    logic                    drive;
    logic                    rd_good;
    assign drive   = !i_pins.cs_n && !i_pins.oe_n;
    assign rd_good = i_pins.cs_n || (drive && i_pins.addr == prev.addr);

    always @* begin
        if (drive && mem.exists(i_pins.addr))
            o_dq = mem[i_pins.addr];
        else if (drive)
            o_dq = '0;
        else
            o_dq = ~last; // No keeper: a released bus must not echo old data
    end

    always @(posedge i_clk) begin
        logic [`PSAG_DATA_W-1:0] w;
        w = mem.exists(i_pins.addr) ? mem[i_pins.addr] : '0;
        prev <= i_pins;
        if (drive)
            last <= o_dq;
        if (!i_pins.cs_n && !i_pins.we_n && !i_pins.dq_oe_n) begin
            if (!i_pins.ram_upper_byte_enable_n)
                w[15:8] = i_pins.dq_out[15:8];
            if (!i_pins.ram_lower_byte_enable_n)
                w[7:0] = i_pins.dq_out[7:0];
            mem[i_pins.addr] = w;
        end
        cs_hi   <= i_pins.cs_n ? cs_hi + 1 : 0;
        cs_lo   <= i_pins.cs_n ? 0 : cs_lo + 1;
        oe_hi   <= (!i_pins.cs_n && i_pins.oe_n) ? oe_hi + 1 : 0;
        we_ok   <= (i_pins.we_n || i_pins.cs_n) ? we_ok + 1 : 0;
        since_w <= (we_ok >= `PSAG_WC_CYC) ? 0 : since_w + 1;
        rd_ok   <= rd_good ? rd_ok + 1 : 0;
        since_r <= (rd_ok >= `PSAG_RC_CYC) ? 0 : since_r + 1;
        ub_hi   <= i_pins.ram_upper_byte_enable_n ? ub_hi + 1 : 0;
        lb_hi   <= i_pins.ram_lower_byte_enable_n ? lb_hi + 1 : 0;
        we_hi   <= (!i_pins.cs_n && i_pins.we_n) ? we_hi + 1 : 0;
        if (!i_pins.oe_n && !i_pins.we_n)
            o_viol[0] <= 1'b1;
        if (!i_pins.cs_n && prev.cs_n && cs_hi < `PSAG_MIN_CYC)
            o_viol[1] <= 1'b1;
        if (!i_pins.cs_n && !prev.cs_n && !i_pins.oe_n && prev.oe_n &&
            oe_hi < `PSAG_MIN_CYC)
            o_viol[2] <= 1'b1;
        if (oe_hi > `PSAG_LVL_CYC)
            o_viol[2] <= 1'b1;
        if (since_w > `PSAG_WIN_CYC)
            o_viol[3] <= 1'b1;
        if (since_r > `PSAG_WIN_CYC)
            o_viol[4] <= 1'b1;
        if (!i_pins.cs_n && ((!i_pins.we_n && !prev.we_n) || prev.cs_n) &&
            i_pins.addr != prev.addr)
            o_viol[5] <= 1'b1;
        if (cs_lo > `PSAG_WIN_CYC)
            o_viol[6] <= 1'b1;
        if ((!i_pins.ram_upper_byte_enable_n &&
             prev.ram_upper_byte_enable_n && ub_hi < `PSAG_MIN_CYC) ||
            (!i_pins.ram_lower_byte_enable_n &&
             prev.ram_lower_byte_enable_n && lb_hi < `PSAG_MIN_CYC))
            o_viol[7] <= 1'b1;
        if (!i_pins.cs_n && !i_pins.we_n && prev.we_n && !prev.oe_n)
            o_viol[8] <= 1'b1;
        if (!i_pins.cs_n && !prev.cs_n && !i_pins.oe_n && prev.oe_n &&
            we_hi < `PSAG_MIN_CYC)
            o_viol[8] <= 1'b1;
        if (i_rst) begin
            {cs_hi, cs_lo, oe_hi, we_ok, since_w, rd_ok, since_r} <= '0;
            {ub_hi, lb_hi, we_hi} <= '0;
            o_viol <= '0;
            last   <= '0;
        end
    end
endmodule

// ---- tb_psag_top.sv ----
`timescale 1ns/1ps
`include "psag_cfg.svh"
module tb_psag_top;
    import psag_pkg::*;
    logic                    clk       = 1'b0;
    logic                    rst       = 1'b1;
    logic                    req_valid = 1'b0;
    psag_req_t               req       = '0;
    logic                    req_ready;
    logic                    rvalid;
    logic [`PSAG_DATA_W-1:0] rdata;
    logic [`PSAG_DATA_W-1:0] ram_dq;
    psag_pins_t              pins;
    logic [8:0]              viol;
    int                      err_total = 0;
    int                      checks    = 0;
    logic [`PSAG_DATA_W-1:0] shadow [logic [`PSAG_ADDR_W-1:0]];
    logic [`PSAG_DATA_W-1:0] exp_q [$];

    always #5 clk = ~clk;

    psag_top u_dut (
        .I_SYS_CLK   (clk),
        .I_RST       (rst),
        .I_REQ_VALID (req_valid),
        .I_REQ       (req),
        .O_REQ_READY (req_ready),
        .O_RDATA     (rdata),
        .O_RVALID    (rvalid),
        .O_RAM       (pins),
        .I_RAM_DQ    (ram_dq)
    );

    psag_ram_model u_ram (
        .i_clk  (clk),
        .i_rst  (rst),
        .i_pins (pins),
        .o_dq   (ram_dq),
        .o_viol (viol)
    );

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp,
                            input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp,
                            input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %b", $time, what, got);
        end
    endtask

    task automatic timeout(input string what);
        err_total++;
        $display("MISMATCH %0t timeout %s", $time, what);
        complete_run();
    endtask

    function automatic logic [15:0] rd_exp(input logic [20:0] a);
        return shadow.exists(a) ? shadow[a] : '0;
    endfunction

    // Reads see the shadow at take time; the controller orders the bus alike
    task automatic send(input logic wr, input logic [20:0] a,
                        input logic [15:0] d, input logic [1:0] be);
        int n;
        logic [15:0] old;
        req_valid = 1'b1;
        req = '{wr, a, d, be[1], be[0]};
        @(negedge clk);
        for (n = 0; n < 1000 && req_ready !== 1'b1; n++)
            @(negedge clk);
        if (n == 1000)
            timeout("request");
        @(posedge clk);
        #1;
        old = rd_exp(a);
        if (wr)
            shadow[a] = {be[1] ? old[15:8] : d[15:8],
                         be[0] ? old[7:0] : d[7:0]};
        else
            exp_q.push_back(rd_exp(a));
    endtask

    task automatic rand_op(input logic wr);
        send(wr, {4'($urandom), 15'h0, 2'($urandom)}, 16'($urandom),
             2'($urandom));
    endtask

    task automatic pause(input int n);
        req_valid = 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic drain();
        int n;
        req_valid = 1'b0;
        for (n = 0; n < 3000 && exp_q.size() > 0; n++)
            @(posedge clk);
        if (exp_q.size() > 0)
            timeout("read data");
        pause(30);
    endtask

    task automatic chk_idle();
        cmp_flag(pins.cs_n, 1'b1, "idle select");
        cmp_flag(pins.oe_n & pins.we_n & pins.dq_oe_n, 1'b1, "idle strobes");
        cmp_flag(req_ready, 1'b1, "idle ready");
        cmp_flag(rvalid, 1'b0, "idle rvalid");
    endtask

    task automatic end_test(input string name);
        cmp_flag(viol[0], 1'b0, "oe and we low");
        cmp_flag(viol[1], 1'b0, "short deselect");
        cmp_flag(viol[2], 1'b0, "oe high span");
        cmp_flag(viol[3], 1'b0, "no write rest");
        cmp_flag(viol[4], 1'b0, "no read rest");
        cmp_flag(viol[5], 1'b0, "address moved");
        cmp_flag(viol[6], 1'b0, "select too long");
        cmp_flag(viol[7], 1'b0, "short byte release");
        cmp_flag(viol[8], 1'b0, "oe to we spacing");
        $display("Test %s done, mismatches %0d", name, err_total);
    endtask

    always @(negedge clk) begin
        if (rvalid === 1'b1 && exp_q.size() == 0)
            cmp_flag(1'b1, 1'b0, "unexpected read");
        else if (rvalid === 1'b1)
            cmp_data(rdata, exp_q.pop_front(), "read data");
    end

    initial begin
        logic wr;
        void'($urandom(75));
        repeat (16) @(posedge clk);
        #1;
        chk_idle();
        rst = 1'b0;
        for (int b = 0; b < 4; b++)
            send(1'b1, 21'h1abcd, 16'($urandom), 2'(b));
        pause(1);
        drain();
        send(1'b0, 21'h1abcd, 16'h0, 2'b00);
        req_valid = 1'b0;
        // Setup edge plus eleven read edges; the pulse follows the twelfth
        repeat (11) @(posedge clk);
        #1;
        cmp_flag(rvalid, 1'b0, "early rvalid");
        @(posedge clk);
        #1;
        cmp_flag(rvalid, 1'b1, "read latency");
        drain();
        end_test("bytes");
        for (int k = 0; k < 14; k++) begin
            wr = 1'($urandom);
            repeat ($urandom_range(1, 6)) rand_op(wr);
            if ($urandom_range(0, 1) == 1)
                pause($urandom_range(1, 4));
        end
        drain();
        end_test("random");
        repeat (45) rand_op(1'b0);
        repeat (65) rand_op(1'b1);
        drain();
        end_test("long chains");
        rand_op(1'b0);
        req_valid = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        exp_q.delete();
        chk_idle();
        rst = 1'b0;
        rand_op(1'b1);
        rand_op(1'b0);
        drain();
        end_test("reset");
        complete_run();
    end
endmodule
